// ==== src/usb_addr_diag_defs.svh ====
`ifndef USB_ADDR_DIAG_DEFS_SVH
`define USB_ADDR_DIAG_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the local register port)
// ----------------------------------------------------------------------
`define UAD_OFS_SOF_UPPER   8'h1B
`define UAD_OFS_DEV_ADDR    8'h1C
`define UAD_OFS_FAULT_CTL   8'h31
`define UAD_OFS_TEST_SEL    8'h32

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UAD_SOF_HI_MSB      2
`define UAD_ADDR_IMM_BIT    7
`define UAD_ADDR_MSB        6
`define UAD_FI_FORCE_IN     5
`define UAD_FI_FAST         4
`define UAD_FI_RX_ERR       2
`define UAD_FI_NO_STUFF     1
`define UAD_FI_CRC_ERR      0
`define UAD_TEST_MSB        2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UAD_RST_ADDR        7'h00
`define UAD_RST_FRAME_HI    3'h0
`define UAD_RST_TEST_SEL    3'h0
`define UAD_RST_FORCE_IN    1'b1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define UAD_CLK_PERIOD_NS   50
`define UAD_FRAME_NS        1000000
`define UAD_FAST_FRAME_NS   1000
`define UAD_FRAME_CYCLES    (`UAD_FRAME_NS / `UAD_CLK_PERIOD_NS)
`define UAD_FAST_CYCLES     (`UAD_FAST_FRAME_NS / `UAD_CLK_PERIOD_NS)

`endif

// ==== src/usb_addr_diag_pkg.sv ====
package usb_addr_diag_pkg;

	// ----------------------------------------------------------------------
	// operating state chosen by the compliance test selector
	// ----------------------------------------------------------------------
	typedef enum logic [5:0] {
		TS_NORMAL       = 6'h01,
		TS_TEST_J       = 6'h02,
		TS_TEST_K       = 6'h04,
		TS_TEST_SE0_NAK = 6'h08,
		TS_TEST_PACKET  = 6'h10,
		TS_FORCE_ENABLE = 6'h20
	} test_state_t;

	// ----------------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic        force_inputs;
		logic        fast_times;
		logic        force_rx_err;
		logic        no_tx_stuff;
		logic        force_crc_err;
	} diag_ctl_t;

	typedef struct packed {
		logic        valid;
		logic [10:0] frame;
	} sof_t;

endpackage : usb_addr_diag_pkg

// ==== src/usb_addr_update.sv ====
`include "usb_addr_diag_defs.svh"

// device address with deferred or immediate adoption
module usb_addr_update
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	input  wire logic       status_ok,
	input  wire logic       bus_reset,
	output logic      [6:0] cur_addr_ff
);

	logic [6:0] pend_addr_ff;
	logic       pend_valid_ff;
	logic [6:0] nxt_cur_addr;
	logic [6:0] nxt_pend_addr;
	logic       nxt_pend_valid;

	// ----------------------------------------------------------------------
	// address next state
	// ----------------------------------------------------------------------
	// a status completion in the same cycle as a new deferred write applies the old
	// pending value; the new one waits for the following status phase
	always_comb
	begin
		nxt_cur_addr   = cur_addr_ff;
		nxt_pend_addr  = pend_addr_ff;
		nxt_pend_valid = pend_valid_ff;
		if (status_ok && pend_valid_ff)
		begin
			nxt_cur_addr   = pend_addr_ff; // RQ4
			nxt_pend_valid = 1'b0;
		end
		if (wr_en)
		begin
			if (wdata[`UAD_ADDR_IMM_BIT])
			begin
				nxt_cur_addr   = wdata[`UAD_ADDR_MSB:0]; // RQ3
				nxt_pend_valid = 1'b0;
			end
			else
			begin
				nxt_pend_addr  = wdata[`UAD_ADDR_MSB:0]; // RQ4
				nxt_pend_valid = 1'b1;
			end
		end
		// bus reset overrides everything, pending value dropped too
		if (bus_reset)
		begin
			nxt_cur_addr   = `UAD_RST_ADDR; // RQ5
			nxt_pend_valid = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cur_addr_ff   <= `UAD_RST_ADDR;
			pend_addr_ff  <= `UAD_RST_ADDR;
			pend_valid_ff <= 1'b0;
		end
		else
		begin
			cur_addr_ff   <= nxt_cur_addr;
			pend_addr_ff  <= nxt_pend_addr;
			pend_valid_ff <= nxt_pend_valid;
		end
	end

endmodule : usb_addr_update

// ==== src/usb_fault_inject.sv ====
`include "usb_addr_diag_defs.svh"

// diagnostic fault injection bits with one-shot self clearing
module usb_fault_inject
(
	input  wire logic                         mclk,
	input  wire logic                         resetn,
	input  wire logic                         wr_en,
	input  wire logic [7:0]                   wdata,
	input  wire logic                         rx_pkt_end,
	input  wire logic                         tx_pkt_end,
	output usb_addr_diag_pkg::diag_ctl_t      diag_ff
);

	usb_addr_diag_pkg::diag_ctl_t nxt_diag;

	// ----------------------------------------------------------------------
	// diagnostic next state
	// ----------------------------------------------------------------------
	// one-shot bits: writing one arms, writing zero has no effect, the
	// packet end disarms; an arming write in the end cycle wins
	always_comb
	begin
		nxt_diag = diag_ff;
		if (rx_pkt_end)
			nxt_diag.force_rx_err = 1'b0; // RQ8
		if (tx_pkt_end)
		begin
			nxt_diag.no_tx_stuff   = 1'b0; // RQ9
			nxt_diag.force_crc_err = 1'b0; // RQ10
		end
		if (wr_en)
		begin
			nxt_diag.force_inputs = wdata[`UAD_FI_FORCE_IN]; // RQ6
			nxt_diag.fast_times   = wdata[`UAD_FI_FAST]; // RQ7
			if (wdata[`UAD_FI_RX_ERR])
				nxt_diag.force_rx_err = 1'b1; // RQ8
			if (wdata[`UAD_FI_NO_STUFF])
				nxt_diag.no_tx_stuff = 1'b1; // RQ9
			if (wdata[`UAD_FI_CRC_ERR])
				nxt_diag.force_crc_err = 1'b1; // RQ10
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			diag_ff.force_inputs  <= `UAD_RST_FORCE_IN; // RQ6
			diag_ff.fast_times    <= 1'b0;
			diag_ff.force_rx_err  <= 1'b0;
			diag_ff.no_tx_stuff   <= 1'b0;
			diag_ff.force_crc_err <= 1'b0;
		end
		else
			diag_ff <= nxt_diag;
	end

endmodule : usb_fault_inject

// ==== src/usb_device_addr_diag_regs.sv ====
`include "usb_addr_diag_defs.svh"

// What this block does
// RQ1: frame high register reads frame bits 10..8 of the latest start-of-frame in bits 2..0, rest zero.
// RQ2: address register bit 7 only acts on a write and always reads zero.
// RQ3: an address write with bit 7 set makes the new address current at once.
// RQ4: an address write with bit 7 clear is held pending until the control status phase succeeds.
// RQ5: a root port reset clears the current address to zero.
// RQ6: diagnostic bit 5, set after reset, turns every two-way pin into an input in chip test mode.
// RQ7: diagnostic bit 4 runs the frame timer at a fast rate for production test.
// RQ8: diagnostic bit 2 fails the next received data packet and clears itself at that packet's end.
// RQ9: diagnostic bit 1 drops bit stuffing in the next transmitted data packet and then clears.
// RQ10: diagnostic bit 0 inverts the CRC msb of the next transmitted data packet and then clears.
// RQ11: the 3-bit test selector picks normal, Test_J, Test_K, Test_SE0_NAK, Test_Packet or Test_Force_Enable.
// RQ12: writes to reserved or read-only fields change nothing.
module usb_device_addr_diag_regs
#(
	parameter int unsigned PIN_W        = 8,
	parameter int unsigned FRAME_CYCLES = `UAD_FRAME_CYCLES,
	parameter int unsigned FAST_CYCLES  = `UAD_FAST_CYCLES
)
(
	input  wire logic                         mclk,
	input  wire logic                         resetn,
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [7:0]                   reg_rdata,
	input  wire usb_addr_diag_pkg::sof_t      sof,
	input  wire logic                         status_ok,
	input  wire logic                         bus_reset,
	input  wire logic                         rx_pkt_end,
	input  wire logic                         tx_pkt_end,
	input  wire logic                         chip_test_mode,
	input  wire logic [PIN_W-1:0]             core_oe,
	output logic      [6:0]                   dev_addr,
	output usb_addr_diag_pkg::diag_ctl_t      diag,
	output logic      [PIN_W-1:0]             pad_oe,
	output usb_addr_diag_pkg::test_state_t    test_state,
	output logic                              frame_tick
);

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// reserved selector codes fall back to normal operation
	function automatic usb_addr_diag_pkg::test_state_t code_to_state(input logic [2:0] code);
		case (code)
			3'h0:    code_to_state = usb_addr_diag_pkg::TS_NORMAL;
			3'h1:    code_to_state = usb_addr_diag_pkg::TS_TEST_J;
			3'h2:    code_to_state = usb_addr_diag_pkg::TS_TEST_K;
			3'h3:    code_to_state = usb_addr_diag_pkg::TS_TEST_SE0_NAK;
			3'h4:    code_to_state = usb_addr_diag_pkg::TS_TEST_PACKET;
			3'h5:    code_to_state = usb_addr_diag_pkg::TS_FORCE_ENABLE;
			default: code_to_state = usb_addr_diag_pkg::TS_NORMAL;
		endcase
	endfunction : code_to_state

	localparam int unsigned CNT_W = $clog2(FRAME_CYCLES + 1);
	localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_CYCLES - 1);
	localparam logic [CNT_W-1:0] FAST_LAST  = CNT_W'(FAST_CYCLES - 1);

	// ----------------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------------
	logic                          wr_addr_reg;
	logic                          wr_fault;
	logic                          wr_test;
	logic [7:0]                    rd_data_ff;
	logic [7:0]                    nxt_rd_data;
	logic [2:0]                    frame_hi_ff;
	logic [2:0]                    nxt_frame_hi;
	logic [2:0]                    test_sel_ff;
	logic [2:0]                    nxt_test_sel;
	usb_addr_diag_pkg::test_state_t test_state_ff;
	usb_addr_diag_pkg::test_state_t nxt_test_state;
	logic [CNT_W-1:0]              frame_cnt_ff;
	logic [CNT_W-1:0]              nxt_frame_cnt;
	logic                          frame_tick_ff;
	logic                          nxt_frame_tick;
	logic [PIN_W-1:0]              pad_oe_ff;
	logic [PIN_W-1:0]              nxt_pad_oe;
	logic [6:0]                    cur_addr;
	usb_addr_diag_pkg::diag_ctl_t  diag_state;

	// ----------------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------------
	// the frame high register has no write path at all
	assign wr_addr_reg = reg_wr && reg_hit(reg_addr, `UAD_OFS_DEV_ADDR);
	assign wr_fault    = reg_wr && reg_hit(reg_addr, `UAD_OFS_FAULT_CTL);
	assign wr_test     = reg_wr && reg_hit(reg_addr, `UAD_OFS_TEST_SEL);

	// ----------------------------------------------------------------------
	// device address
	// ----------------------------------------------------------------------
	usb_addr_update u_addr
	(
		.mclk        (mclk),
		.resetn      (resetn),
		.wr_en       (wr_addr_reg),
		.wdata       (reg_wdata),
		.status_ok   (status_ok),
		.bus_reset   (bus_reset),
		.cur_addr_ff (cur_addr)
	);

	// ----------------------------------------------------------------------
	// fault injection
	// ----------------------------------------------------------------------
	usb_fault_inject u_fault
	(
		.mclk       (mclk),
		.resetn     (resetn),
		.wr_en      (wr_fault),
		.wdata      (reg_wdata),
		.rx_pkt_end (rx_pkt_end),
		.tx_pkt_end (tx_pkt_end),
		.diag_ff    (diag_state)
	);

	// ----------------------------------------------------------------------
	// frame number capture
	// ----------------------------------------------------------------------
	// only the top three frame bits are kept here; the low byte lives elsewhere
	always_comb
	begin
		nxt_frame_hi = frame_hi_ff;
		if (sof.valid)
			nxt_frame_hi = sof.frame[10:8]; // RQ1
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			frame_hi_ff <= `UAD_RST_FRAME_HI;
		else
			frame_hi_ff <= nxt_frame_hi;
	end

	// ----------------------------------------------------------------------
	// compliance test selector
	// ----------------------------------------------------------------------
	// reserved codes are stored and read back, but drive normal operation
	always_comb
	begin
		nxt_test_sel = test_sel_ff;
		if (wr_test)
			nxt_test_sel = reg_wdata[`UAD_TEST_MSB:0]; // RQ12
		nxt_test_state = code_to_state(nxt_test_sel); // RQ11
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			test_sel_ff   <= `UAD_RST_TEST_SEL;
			test_state_ff <= usb_addr_diag_pkg::TS_NORMAL;
		end
		else
		begin
			test_sel_ff   <= nxt_test_sel;
			test_state_ff <= nxt_test_state;
		end
	end

	// ----------------------------------------------------------------------
	// frame timer
	// ----------------------------------------------------------------------
	// restarts on every start-of-frame so the tick tracks the host; the fast
	// rate is only useful on a tester, a real host would never match it
	always_comb
	begin
		nxt_frame_tick = 1'b0;
		nxt_frame_cnt  = frame_cnt_ff + CNT_W'(1);
		if (sof.valid)
			nxt_frame_cnt = '0;
		else if (diag_state.fast_times ? (frame_cnt_ff >= FAST_LAST) // RQ7
		                               : (frame_cnt_ff >= FRAME_LAST))
		begin
			nxt_frame_cnt  = '0;
			nxt_frame_tick = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			frame_cnt_ff  <= '0;
			frame_tick_ff <= 1'b0;
		end
		else
		begin
			frame_cnt_ff  <= nxt_frame_cnt;
			frame_tick_ff <= nxt_frame_tick;
		end
	end

	// ----------------------------------------------------------------------
	// two-way pin direction override
	// ----------------------------------------------------------------------
	// costs one cycle of enable latency, accepted to keep outputs registered
	always_comb
	begin
		nxt_pad_oe = core_oe;
		if (chip_test_mode && diag_state.force_inputs)
			nxt_pad_oe = '0; // RQ6
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			pad_oe_ff <= '0;
		else
			pad_oe_ff <= nxt_pad_oe;
	end

	// ----------------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------------
	// data valid only in the cycle after the strobe, zero otherwise and for
	// unmapped addresses
	always_comb
	begin
		nxt_rd_data = 8'h00;
		if (reg_rd)
		begin
			if (reg_hit(reg_addr, `UAD_OFS_SOF_UPPER))
				nxt_rd_data = {5'h00, frame_hi_ff}; // RQ1
			else if (reg_hit(reg_addr, `UAD_OFS_DEV_ADDR))
				nxt_rd_data = {1'b0, cur_addr}; // RQ2
			else if (reg_hit(reg_addr, `UAD_OFS_FAULT_CTL))
				nxt_rd_data = {2'b00,
				               diag_state.force_inputs,
				               diag_state.fast_times,
				               1'b0, // RQ12
				               diag_state.force_rx_err,
				               diag_state.no_tx_stuff,
				               diag_state.force_crc_err};
			else if (reg_hit(reg_addr, `UAD_OFS_TEST_SEL))
				nxt_rd_data = {5'h00, test_sel_ff};
			else
				nxt_rd_data = 8'h00;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rd_data_ff <= 8'h00;
		else
			rd_data_ff <= nxt_rd_data;
	end

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	assign reg_rdata  = rd_data_ff;
	assign dev_addr   = cur_addr;
	assign diag       = diag_state;
	assign pad_oe     = pad_oe_ff;
	assign test_state = test_state_ff;
	assign frame_tick = frame_tick_ff;

endmodule : usb_device_addr_diag_regs

// ==== verif/usb_device_addr_diag_regs_properties.sv ====
`include "usb_addr_diag_defs.svh"

// ----------------------------------------------------------------------
// port checker for the address and diagnostic register bank
// ----------------------------------------------------------------------
module usb_device_addr_diag_regs_chk
#(
	parameter int unsigned PIN_W        = 8,
	parameter int unsigned FRAME_CYCLES = 64,
	parameter int unsigned FAST_CYCLES  = 8
)
(
	input wire logic                           mclk,
	input wire logic                           resetn,
	input wire logic [7:0]                     reg_addr,
	input wire logic [7:0]                     reg_wdata,
	input wire logic                           reg_wr,
	input wire logic                           reg_rd,
	input wire logic [7:0]                     reg_rdata,
	input wire usb_addr_diag_pkg::sof_t        sof,
	input wire logic                           status_ok,
	input wire logic                           bus_reset,
	input wire logic                           rx_pkt_end,
	input wire logic                           tx_pkt_end,
	input wire logic                           chip_test_mode,
	input wire logic [PIN_W-1:0]               core_oe,
	input wire logic [6:0]                     dev_addr,
	input wire usb_addr_diag_pkg::diag_ctl_t   diag,
	input wire logic [PIN_W-1:0]               pad_oe,
	input wire usb_addr_diag_pkg::test_state_t test_state,
	input wire logic                           frame_tick
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	// decoded strobes keep the properties short
	wire logic addr_wr  = reg_wr && (reg_addr == `UAD_OFS_DEV_ADDR);
	wire logic fault_wr = reg_wr && (reg_addr == `UAD_OFS_FAULT_CTL);
	wire logic test_wr  = reg_wr && (reg_addr == `UAD_OFS_TEST_SEL);

	sof_read_a: assert property (reg_rd && reg_addr == `UAD_OFS_SOF_UPPER |=> reg_rdata[7:3] == 5'h00)
		else $error("frame high reserved bits not zero");
	imm_flag_read_a: assert property (reg_rd && reg_addr == `UAD_OFS_DEV_ADDR |=> !reg_rdata[7])
		else $error("immediate flag read back as one");
	imm_update_a: assert property (addr_wr && reg_wdata[7] && !bus_reset |=> dev_addr == $past(reg_wdata[6:0]))
		else $error("immediate address not adopted");
	defer_hold_a: assert property (addr_wr && !reg_wdata[7] && !status_ok && !bus_reset |=> $stable(dev_addr))
		else $error("deferred address applied early");
	bus_reset_clr_a: assert property (bus_reset |=> dev_addr == 7'h00)
		else $error("address not cleared by bus reset");
	force_input_a: assert property (chip_test_mode && diag.force_inputs |=> pad_oe == '0)
		else $error("pin driven while forced to input");
	rx_err_clear_a: assert property (rx_pkt_end && !(fault_wr && reg_wdata[2]) |=> !diag.force_rx_err)
		else $error("receive error bit kept after packet");
	tx_bits_clear_a: assert property (tx_pkt_end && !(fault_wr && reg_wdata[1:0] != 2'h0)
		|=> !diag.no_tx_stuff && !diag.force_crc_err)
		else $error("transmit fault bits kept after packet");
	test_resv_a: assert property (test_wr && reg_wdata[2:1] == 2'h3
		|=> test_state == usb_addr_diag_pkg::TS_NORMAL)
		else $error("reserved test code not normal");
	read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	// main scenarios reached
	cov_defer: cover property (addr_wr && !reg_wdata[7] ##[1:20] status_ok);
	cov_fast: cover property (diag.fast_times && frame_tick);
	cov_force: cover property (chip_test_mode && diag.force_inputs);
endmodule : usb_device_addr_diag_regs_chk

bind usb_device_addr_diag_regs usb_device_addr_diag_regs_chk #(.PIN_W(PIN_W),
	.FRAME_CYCLES(FRAME_CYCLES), .FAST_CYCLES(FAST_CYCLES)) u_chk (.mclk(mclk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .sof(sof), .status_ok(status_ok), .bus_reset(bus_reset),
	.rx_pkt_end(rx_pkt_end), .tx_pkt_end(tx_pkt_end), .chip_test_mode(chip_test_mode),
	.core_oe(core_oe), .dev_addr(dev_addr), .diag(diag), .pad_oe(pad_oe),
	.test_state(test_state), .frame_tick(frame_tick));

// ==== verif/usb_host_model.sv ====
// ----------------------------------------------------------------------
// bus side events as the host traffic would raise them
// ----------------------------------------------------------------------
module usb_host_model
(
	input  wire logic              mclk,
	output usb_addr_diag_pkg::sof_t sof,
	output logic                   status_ok,
	output logic                   bus_reset,
	output logic                   rx_pkt_end,
	output logic                   tx_pkt_end
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		sof = 12'h0AA;
		status_ok = 1'b0;
		bus_reset = 1'b0;
		rx_pkt_end = 1'b0;
		tx_pkt_end = 1'b0;
	end

	// one-cycle event: 0 sof, 1 status done, 2 bus reset, 3 rx end, 4 tx end
	task automatic pulse(input int which, input logic [10:0] frame);
		@(posedge mclk);
		case (which)
			0: sof <= {1'b1, frame};
			1: status_ok <= 1'b1;
			2: bus_reset <= 1'b1;
			3: rx_pkt_end <= 1'b1;
			default: tx_pkt_end <= 1'b1;
		endcase
		@(posedge mclk);
		// frame field is stale outside the pulse, so show its inverse
		sof <= {1'b0, ~frame};
		status_ok <= 1'b0;
		bus_reset <= 1'b0;
		rx_pkt_end <= 1'b0;
		tx_pkt_end <= 1'b0;
	endtask : pulse
endmodule : usb_host_model

// ==== verif/test_usb_device_addr_diag_regs.sv ====
`include "usb_addr_diag_defs.svh"

module test_usb_device_addr_diag_regs;
	timeunit 1ns;
	timeprecision 1ps;

	logic                                mclk;
	logic                                resetn;
	logic [7:0]                          reg_addr;
	logic [7:0]                          reg_wdata;
	logic                                reg_wr;
	logic                                reg_rd;
	logic [7:0]                          reg_rdata;
	usb_addr_diag_pkg::sof_t             sof;
	logic                                status_ok;
	logic                                bus_reset;
	logic                                rx_pkt_end;
	logic                                tx_pkt_end;
	logic                                chip_test_mode;
	logic [7:0]                          core_oe;
	logic [6:0]                          dev_addr;
	usb_addr_diag_pkg::diag_ctl_t        diag;
	logic [7:0]                          pad_oe;
	usb_addr_diag_pkg::test_state_t      test_state;
	logic                                frame_tick;
	int                                  err_total;
	int                                  n_compared;

	usb_device_addr_diag_regs #(.PIN_W(8), .FRAME_CYCLES(64), .FAST_CYCLES(8)) u_dut (
		.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sof(sof),
		.status_ok(status_ok), .bus_reset(bus_reset), .rx_pkt_end(rx_pkt_end),
		.tx_pkt_end(tx_pkt_end), .chip_test_mode(chip_test_mode), .core_oe(core_oe),
		.dev_addr(dev_addr), .diag(diag), .pad_oe(pad_oe), .test_state(test_state),
		.frame_tick(frame_tick));

	usb_host_model u_host (.mclk(mclk), .sof(sof), .status_ok(status_ok),
		.bus_reset(bus_reset), .rx_pkt_end(rx_pkt_end), .tx_pkt_end(tx_pkt_end));

	// ----------------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wait_cyc

	// cycles between two frame ticks, bounded so a dead timer ends the run
	task automatic tick_gap(output int gap);
		int k;
		#1; // step off the edge that may be launching the tick
		for (k = 0; k < 300 && frame_tick !== 1'b1; k++)
			wait_cyc(1);
		gap = 0;
		do
		begin
			wait_cyc(1);
			gap++;
		end
		while (frame_tick !== 1'b1 && gap < 300);
		if (k >= 300 || gap >= 300)
		begin
			err_total++;
			end_sim();
		end
	endtask : tick_gap

	// ----------------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------------
	task automatic reset_values;
		logic [7:0] d;
		rd(`UAD_OFS_FAULT_CTL, d);
		check("fault reset", d, 16'h0020);
		rd(`UAD_OFS_TEST_SEL, d);
		check("test reset", d, 16'h0000);
		rd(8'h50, d);
		check("unmapped read", d, 16'h0000);
		check("state reset", test_state, usb_addr_diag_pkg::TS_NORMAL);
	endtask : reset_values

	task automatic frame_upper;
		logic [7:0] d;
		u_host.pulse(0, 11'h5A3);
		rd(`UAD_OFS_SOF_UPPER, d);
		check("frame high", d, 16'h0005);
		wr(`UAD_OFS_SOF_UPPER, 8'hFF);
		rd(`UAD_OFS_SOF_UPPER, d);
		check("frame high ro", d, 16'h0005);
	endtask : frame_upper

	task automatic address_update;
		logic [7:0] d;
		wr(`UAD_OFS_DEV_ADDR, 8'h85);
		wait_cyc(1);
		check("imm addr", dev_addr, 16'h0005);
		rd(`UAD_OFS_DEV_ADDR, d);
		check("addr read", d, 16'h0005);
		wr(`UAD_OFS_DEV_ADDR, 8'h12);
		wait_cyc(3);
		check("pending held", dev_addr, 16'h0005);
		u_host.pulse(1, 11'h000);
		wait_cyc(2);
		check("pending applied", dev_addr, 16'h0012);
		wr(`UAD_OFS_DEV_ADDR, 8'h33);
		u_host.pulse(2, 11'h000);
		u_host.pulse(1, 11'h000);
		wait_cyc(2);
		check("bus reset addr", dev_addr, 16'h0000);
	endtask : address_update

	task automatic fault_bits;
		logic [7:0] d;
		wr(`UAD_OFS_FAULT_CTL, 8'hFF);
		rd(`UAD_OFS_FAULT_CTL, d);
		check("fault all set", d, 16'h0037);
		wr(`UAD_OFS_FAULT_CTL, 8'h00);
		rd(`UAD_OFS_FAULT_CTL, d);
		check("one-shots kept", d, 16'h0007);
		check("diag port", diag, 16'h0007);
		u_host.pulse(3, 11'h000);
		rd(`UAD_OFS_FAULT_CTL, d);
		check("rx end clears", d, 16'h0003);
		u_host.pulse(4, 11'h000);
		rd(`UAD_OFS_FAULT_CTL, d);
		check("tx end clears", d, 16'h0000);
	endtask : fault_bits

	task automatic pin_force;
		@(posedge mclk);
		chip_test_mode <= 1'b1;
		wait_cyc(3);
		check("pins free", pad_oe, 16'h00A5);
		wr(`UAD_OFS_FAULT_CTL, 8'h20);
		wait_cyc(3);
		check("pins forced", pad_oe, 16'h0000);
		@(posedge mclk);
		chip_test_mode <= 1'b0;
		wait_cyc(3);
		check("pins released", pad_oe, 16'h00A5);
	endtask : pin_force

	task automatic frame_rate;
		int gap;
		wr(`UAD_OFS_FAULT_CTL, 8'h10);
		tick_gap(gap);
		check("fast frame", gap[15:0], 16'h0008);
		wr(`UAD_OFS_FAULT_CTL, 8'h00);
		tick_gap(gap);
		tick_gap(gap);
		check("normal frame", gap[15:0], 16'h0040);
	endtask : frame_rate

	task automatic test_modes;
		logic [7:0] d;
		logic [5:0] exp;
		for (int c = 0; c < 8; c++)
		begin
			exp = (c < 6) ? 6'h01 << c : 6'h01;
			wr(`UAD_OFS_TEST_SEL, 8'hF8 | c[7:0]);
			rd(`UAD_OFS_TEST_SEL, d);
			check("test code", d, c[15:0]);
			check("test state", test_state, exp);
		end
	endtask : test_modes

	// ----------------------------------------------------------------------
	// clock, reset and main sequence
	// ----------------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial
	begin
		err_total = 0;
		n_compared = 0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chip_test_mode = 1'b0;
		core_oe = 8'hA5;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		reset_values();
		frame_upper();
		address_update();
		fault_bits();
		pin_force();
		frame_rate();
		test_modes();
		end_sim();
	end
endmodule : test_usb_device_addr_diag_regs
